/* File: poled_chk_sva.sv */
`timescale 1ns/1ns
module poled_chk #(
  parameter TICK_CYCLES = 20000
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_we,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Fade periods
  input wire [7:0] global_fade_period_one,
  input wire [7:0] global_fade_period_two,
  input wire [7:0] global_fade_period_three,
  input wire [7:0] global_fade_period_four,
  // Outputs
  input wire [9:0] general_output_n,
  input wire [3:0] effect_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Busy spread to one bit per output
  wire [9:0] busy10 = {{3{effect_busy[3]}}, {3{effect_busy[2]}},
                       {3{effect_busy[1]}}, effect_busy[0]};
  // A mapped write, then the same offset read with no write
  sequence s_write;
    reg_we && reg_addr inside {[8'h12:8'h19]};
  endsequence
  sequence s_reread;
    !reg_we && reg_addr == $past(reg_addr);
  endsequence
  a_reset_all_off: assert property (disable iff (1'b0) reset |=>
      general_output_n == 10'h3ff && effect_busy == 4'h0 && reg_rdata == 8'h00)
    else $error("outputs not idle after reset");
  a_unmapped_zero: assert property (!(reg_addr inside {[8'h12:8'h19]})
      |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_write_reread: assert property (s_write ##1 s_reread
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("written value not read back");
  a_rdata_steady: assert property (!reg_we && !$past(reg_we) && $stable(reg_addr)
      |=> $stable(reg_rdata))
    else $error("read data moved without cause");
  a_busy_start: assert property ($fell(reset) |=> effect_busy == 4'hf)
    else $error("effect did not start after reset");
  a_busy_no_rise: assert property ((effect_busy & ~$past(effect_busy)) != 4'h0
      |-> $past(reset, 2))
    else $error("effect restarted without reset");
  a_idle_dark: assert property (((~busy10 & ~$past(busy10)) & ~general_output_n)
      == 10'h000)
    else $error("led lit while idle");
  a_group_same: assert property (general_output_n[3:1] inside {3'h0, 3'h7}
      && general_output_n[6:4] inside {3'h0, 3'h7}
      && general_output_n[9:7] inside {3'h0, 3'h7})
    else $error("outputs of one group differ");
endmodule // poled_chk
bind poled_top poled_chk #(.TICK_CYCLES(TICK_CYCLES)) poled_chk_i (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .global_fade_period_one(global_fade_period_one), .global_fade_period_two(global_fade_period_two),
  .global_fade_period_three(global_fade_period_three),
  .global_fade_period_four(global_fade_period_four),
  .general_output_n(general_output_n), .effect_busy(effect_busy));

/* File: poled_defines.vh */
`ifndef POLED_DEFINES_VH
`define POLED_DEFINES_VH
// Register offsets, eight bits each
`define POLED_OFS_A_OUT0 8'h12
`define POLED_OFS_B_OUT0 8'h13
`define POLED_OFS_A_OUT1_3 8'h14
`define POLED_OFS_B_OUT1_3 8'h15
`define POLED_OFS_A_OUT4_6 8'h16
`define POLED_OFS_B_OUT4_6 8'h17
`define POLED_OFS_A_OUT7_9 8'h18
`define POLED_OFS_B_OUT7_9 8'h19
`define POLED_OFS_FIRST 8'h12
`define POLED_OFS_LAST 8'h19
`define POLED_RESET_VAL 8'h00
// First register fields
`define POLED_RU_HI 7
`define POLED_RU_LO 6
`define POLED_HB_HI 5
`define POLED_HB_LO 3
`define POLED_REP_HI 2
`define POLED_REP_LO 0
// Second register fields
`define POLED_RD_HI 7
`define POLED_RD_LO 6
`define POLED_LB_HI 5
`define POLED_LB_LO 3
`define POLED_TH_HI 2
`define POLED_TH_LO 1
`define POLED_TL_BIT 0
// Timing: one fade-period unit in microseconds, clock in MHz
`define POLED_TICK_US 1000
`define POLED_CLK_MHZ 20
`define POLED_PWM_STEPS 7'h64
`endif

/* File: poled_led_model.sv */
`timescale 1ns/1ns
module poled_led_model (
  // Clock and reset
  input wire clk,
  input wire reset,
  // LED drive, lit when low
  input wire [9:0] general_output_n,
  // Lit cycles seen per LED
  output int lit_cnt [10]
);
  // Case equality so an undriven pin never counts as lit
  always @(posedge clk) begin
    for (int i = 0; i < 10; i++) begin
      if (reset) lit_cnt[i] <= 0;
      else if (general_output_n[i] === 1'b0) lit_cnt[i] <= lit_cnt[i] + 1;
    end
  end
endmodule // poled_led_model

/* File: poled_top.v */
// Behaviour
// [R1] First register: ramp-up, high target, repeats
// [R2] First registers at 0x12/14/16/18 per group
// [R3] Ramp-up code picks fade period one..four
// [R4] High target codes give 100..0 percent
// [R5] Repeat codes give 0,1,2,4,6 repeats
// [R6] Second register: ramp-down, low target, holds
// [R7] Second registers at 0x13/15/17/19 per group
// [R8] Ramp-down code picks fade period one..four
// [R9] Low target codes give 0..100 percent
// [R10] High hold code picks fade period one..four
// [R11] Low hold bit picks period one or two
// [R12] After reset: ramp up, hold, down, hold, repeat
`timescale 1ns/1ns
`include "poled_defines.vh"
module poled_top #(
  parameter TICK_CYCLES = `POLED_TICK_US * `POLED_CLK_MHZ
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_we,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Global fade periods, in units of one tick
  input wire [7:0] global_fade_period_one,
  input wire [7:0] global_fade_period_two,
  input wire [7:0] global_fade_period_three,
  input wire [7:0] global_fade_period_four,
  // LED outputs, active low
  output reg [9:0] general_output_n,
  // Effect still running, one bit per group
  output reg [3:0] effect_busy
);
  // Effect states, one-hot
  localparam ST_UP = 5'b00001;
  localparam ST_HOLD_HI = 5'b00010;
  localparam ST_DOWN = 5'b00100;
  localparam ST_HOLD_LO = 5'b01000;
  localparam ST_DONE = 5'b10000;

  // Configuration storage, index 0..7 is offset minus the first offset
  reg [7:0] cfg_q [0:7];
  // Shared tick and PWM counters
  reg [31:0] tick_cnt_q;
  reg tick_q;
  reg [6:0] pwm_cnt_q;
  // Per-group lit flag
  wire [3:0] lit;
  integer i;

  // Pick one of four fade periods by code
  function [7:0] period_sel;
    input [1:0] code;
    begin
      case (code)
        2'h0: period_sel = global_fade_period_one;
        2'h1: period_sel = global_fade_period_two;
        2'h2: period_sel = global_fade_period_three;
        default: period_sel = global_fade_period_four;
      endcase
    end
  endfunction

  // High target in percent
  function [6:0] high_pct;
    input [2:0] code;
    begin
      case (code)
        3'h0: high_pct = 7'h64;
        3'h1: high_pct = 7'h5a;
        3'h2: high_pct = 7'h50;
        3'h3: high_pct = 7'h41;
        3'h4: high_pct = 7'h32;
        3'h5: high_pct = 7'h28;
        3'h6: high_pct = 7'h14;
        default: high_pct = 7'h00;
      endcase
    end
  endfunction

  // Low target in percent
  function [6:0] low_pct;
    input [2:0] code;
    begin
      case (code)
        3'h0: low_pct = 7'h00;
        3'h1: low_pct = 7'h0a;
        3'h2: low_pct = 7'h14;
        3'h3: low_pct = 7'h1e;
        3'h4: low_pct = 7'h28;
        3'h5: low_pct = 7'h3c;
        3'h6: low_pct = 7'h50;
        default: low_pct = 7'h64;
      endcase
    end
  endfunction

  // Repeat count; upper codes follow the touch-effect table
  function [4:0] repeat_cnt;
    input [2:0] code;
    begin
      case (code)
        3'h0: repeat_cnt = 5'h00;
        3'h1: repeat_cnt = 5'h01;
        3'h2: repeat_cnt = 5'h02;
        3'h3: repeat_cnt = 5'h04;
        3'h4: repeat_cnt = 5'h06;
        3'h5: repeat_cnt = 5'h0a;
        3'h6: repeat_cnt = 5'h0f;
        default: repeat_cnt = 5'h14;
      endcase
    end
  endfunction

  // Register writes and one-cycle-late reads
  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 8; i = i + 1)
        cfg_q[i] <= `POLED_RESET_VAL;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_we && reg_addr >= `POLED_OFS_FIRST && reg_addr <= `POLED_OFS_LAST) begin
        cfg_q[reg_addr[2:0] - 3'h2] <= reg_wdata; // [R2] [R7]
      end
      if (reg_addr >= `POLED_OFS_FIRST && reg_addr <= `POLED_OFS_LAST) begin
        reg_rdata <= cfg_q[reg_addr[2:0] - 3'h2];
      end else begin
        // Unmapped offsets read as zero
        reg_rdata <= 8'h00;
      end
    end
  end

  // Tick divider and free-running PWM frame of 100 steps
  always @(posedge clk) begin
    if (reset) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
      pwm_cnt_q <= 7'h00;
    end else begin
      tick_q <= (tick_cnt_q == TICK_CYCLES - 1);
      if (tick_cnt_q == TICK_CYCLES - 1) begin
        tick_cnt_q <= 32'h0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
      if (pwm_cnt_q == `POLED_PWM_STEPS - 7'h01) begin
        pwm_cnt_q <= 7'h00;
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 7'h01;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      // Group state
      reg [4:0] state_q;
      reg [7:0] time_q;
      reg [4:0] runs_q;
      reg [6:0] level_q;
      wire [7:0] cfg_a = cfg_q[2 * g]; // [R1]
      wire [7:0] cfg_b = cfg_q[2 * g + 1]; // [R6]
      wire [7:0] t_up = period_sel(cfg_a[`POLED_RU_HI:`POLED_RU_LO]); // [R3]
      wire [6:0] hi_tgt = high_pct(cfg_a[`POLED_HB_HI:`POLED_HB_LO]); // [R4]
      wire [4:0] reps = repeat_cnt(cfg_a[`POLED_REP_HI:`POLED_REP_LO]); // [R5]
      wire [7:0] t_down = period_sel(cfg_b[`POLED_RD_HI:`POLED_RD_LO]); // [R8]
      wire [6:0] lo_tgt = low_pct(cfg_b[`POLED_LB_HI:`POLED_LB_LO]); // [R9]
      wire [7:0] t_hi = period_sel(cfg_b[`POLED_TH_HI:`POLED_TH_LO]); // [R10]
      wire [7:0] t_lo = period_sel({1'b0, cfg_b[`POLED_TL_BIT]}); // [R11]
      assign lit[g] = (level_q > pwm_cnt_q) && (state_q != ST_DONE);

      // Effect sequencer; starts as soon as reset is released
      always @(posedge clk) begin
        if (reset) begin
          state_q <= ST_UP; // [R12]
          time_q <= 8'h00;
          runs_q <= 5'h00;
          level_q <= 7'h00;
        end else if (tick_q) begin
          time_q <= time_q + 8'h01;
          case (state_q)
            ST_UP: begin
              // Step one percent per tick, snap to target when time is up
              if (time_q >= t_up) begin
                level_q <= hi_tgt;
                time_q <= 8'h00;
                state_q <= ST_HOLD_HI; // [R12]
              end else if (level_q < hi_tgt) begin
                level_q <= level_q + 7'h01;
              end else if (level_q > hi_tgt) begin
                level_q <= level_q - 7'h01;
              end
            end
            ST_HOLD_HI: begin
              if (time_q >= t_hi) begin
                time_q <= 8'h00;
                state_q <= ST_DOWN; // [R10]
              end
            end
            ST_DOWN: begin
              if (time_q >= t_down) begin
                level_q <= lo_tgt;
                time_q <= 8'h00;
                state_q <= ST_HOLD_LO; // [R12]
              end else if (level_q > lo_tgt) begin
                level_q <= level_q - 7'h01;
              end else if (level_q < lo_tgt) begin
                level_q <= level_q + 7'h01;
              end
            end
            ST_HOLD_LO: begin
              if (time_q >= t_lo) begin
                time_q <= 8'h00;
                // One pass, then as many repeats as configured
                if (runs_q >= reps) begin
                  state_q <= ST_DONE; // [R5]
                end else begin
                  runs_q <= runs_q + 5'h01;
                  state_q <= ST_UP; // [R12]
                end
              end
            end
            ST_DONE: begin
              time_q <= 8'h00;
            end
            default: begin
              state_q <= ST_DONE;
            end
          endcase
        end
      end
    end
  endgenerate

  // Registered, active-low outputs fanned out to the groups
  always @(posedge clk) begin
    if (reset) begin
      general_output_n <= 10'h3ff;
      effect_busy <= 4'h0;
    end else begin
      general_output_n <= ~{{3{lit[3]}}, {3{lit[2]}}, {3{lit[1]}}, lit[0]}; // [R2] [R7]
      effect_busy <= {grp[3].state_q != ST_DONE, grp[2].state_q != ST_DONE,
                      grp[1].state_q != ST_DONE, grp[0].state_q != ST_DONE};
    end
  end
endmodule // poled_top

/* File: tb_poled_top.sv */
`timescale 1ns/1ns
module tb_poled_top;
  logic clk = 0, reset = 1, reg_we = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] p1 = 8'h03, p2 = 8'h05, p3 = 8'h07, p4 = 8'h09; // Short fade periods, in ticks
  wire [7:0] reg_rdata;
  wire [9:0] general_output_n;
  wire [3:0] effect_busy;
  int lit_cnt [10];
  int dur [4];
  int fails = 0, checks = 0, cycles = 0;
  bit meas = 1;
  // Rows: offset, value written, value read back; unmapped offsets read zero
  logic [7:0] rows [10][3] = '{'{8'h12, 8'ha5, 8'ha5}, '{8'h13, 8'h5a, 8'h5a},
    '{8'h14, 8'hff, 8'hff}, '{8'h15, 8'h01, 8'h01}, '{8'h16, 8'h80, 8'h80},
    '{8'h17, 8'h7e, 8'h7e}, '{8'h18, 8'h3c, 8'h3c}, '{8'h19, 8'hc3, 8'hc3},
    '{8'h11, 8'hff, 8'h00}, '{8'h1a, 8'hff, 8'h00}};
  // Tick of four clocks keeps each effect pass to a few dozen cycles
  poled_top #(.TICK_CYCLES(4)) poled_top_i (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_we(reg_we), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .global_fade_period_one(p1), .global_fade_period_two(p2),
    .global_fade_period_three(p3), .global_fade_period_four(p4),
    .general_output_n(general_output_n), .effect_busy(effect_busy));
  poled_led_model poled_led_model_i (.clk(clk), .reset(reset),
    .general_output_n(general_output_n), .lit_cnt(lit_cnt));
  always #25 clk = ~clk;
  // Busy time per group, and the hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    // Reset clears the busy times so each effect run is measured from zero
    for (int g = 0; g < 4; g++) begin
      if (reset) dur[g] <= 0;
      else if (meas && effect_busy[g] === 1'b1) dur[g] <= dur[g] + 1;
    end
    if (cycles == 30000) begin
      fails++;
      test_done();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_ok(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  // Write strobe stands for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) reg_addr = a;
    reg_we = 1;
    reg_wdata = d;
    @(negedge clk) reg_we = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) reg_addr = a;
    @(negedge clk) cmp8(reg_rdata, e);
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    cmp_ok(general_output_n === 10'h3ff && effect_busy === 4'h0, "not idle in reset");
    reset = 0;
    wr(8'h14, 8'h38);
    wr(8'h16, 8'h04);
    wr(8'h18, 8'hc0);
    for (int i = 0; i < 3000 && effect_busy !== 4'h0; i++) @(negedge clk);
    meas = 0;
    cmp_ok(effect_busy === 4'h0 && general_output_n === 10'h3ff, "effect not over");
    cmp_ok(lit_cnt[0] >= 12 && lit_cnt[1] == 0 && lit_cnt[3] == 0, "brightness");
    cmp_ok(dur[2] > 6 * dur[0], "repeat length");
    cmp_ok(dur[3] > dur[0], "ramp-up length");
    // Back-to-back write and read of every row
    for (int i = 0; i < 10; i++) begin
      wr(rows[i][0], rows[i][1]);
      rd(rows[i][0], rows[i][2]);
    end
    rd(8'h12, 8'ha5);
    // Second reset after the effect has ended brings every register back to zero
    reset = 1;
    meas = 1;
    repeat (3) @(negedge clk);
    reset = 0;
    for (int a = 8'h12; a <= 8'h19; a++) rd(a[7:0], 8'h00);
    // Second registers land while the restarted pass is still holding high
    wr(8'h15, 8'hc0);
    wr(8'h17, 8'h06);
    wr(8'h19, 8'h39);
    for (int i = 0; i < 3000 && effect_busy !== 4'h0; i++) @(negedge clk);
    cmp_ok(effect_busy === 4'h0 && general_output_n === 10'h3ff, "rerun not over");
    // Longer period, in ticks of four clocks, stretches only its own phase
    cmp_ok(dur[1] - dur[0] == 6 * 4, "ramp-down length");
    cmp_ok(dur[2] - dur[0] == 6 * 4, "high hold length");
    cmp_ok(dur[3] - dur[0] == 2 * 4, "low hold length");
    cmp_ok(lit_cnt[7] >= lit_cnt[0] + 16, "low brightness");
    test_done();
  end
endmodule // tb_poled_top
